// ---- bench/safe_io_model.sv ----
// Purpose: Safe input channels and safety fieldbus master model
// Assumes: Safe inputs demand when low, both channels of a pair together
// Notes: Commands come from the bench a little after the clock edge
`timescale 1ns/1ps
module safe_io_model (
  input wire logic [2:0] demand_code, // 0 none, 1-4 single, 5-6 pair
  input wire logic fb_on_cmd, // Fieldbus master activated
  input wire logic fb_req_cmd, // Stop wanted over fieldbus
  output logic safe_input_one, // Low demands
  output logic safe_input_two, // Low demands
  output logic safe_input_three, // Low demands
  output logic safe_input_four, // Low demands
  output logic safety_fieldbus_on, // Fieldbus activated level
  output logic stop_fieldbus_request // Stop request from master
);
  // Pair codes pull both channels low at once
  always_comb begin
    safe_input_one = !(demand_code == 3'h1 || demand_code == 3'h5);
    safe_input_two = !(demand_code == 3'h2 || demand_code == 3'h5);
    safe_input_three = !(demand_code == 3'h3 || demand_code == 3'h6);
    safe_input_four = !(demand_code == 3'h4 || demand_code == 3'h6);
  end
  // A master that is not active sends no request
  assign safety_fieldbus_on = fb_on_cmd;
  assign stop_fieldbus_request = fb_on_cmd & fb_req_cmd;
endmodule

// ---- bench/test_limited_speed_standstill_monitor.sv ----
// Purpose: Self-checking bench for the limited speed monitor
// Assumes: Millisecond shortened to four clocks
// Notes: Settings model in an int array, compared at every read except of the status index
`timescale 1ns/1ps
module test_limited_speed_standstill_monitor;
  localparam int TCK = 4; // Cycles per simulated ms
  logic clk_sys, reset, enc, stop_in, fb_on, fb_req, par_wr_en, par_refused;
  logic s1, s2, s3, s4, fb_line, fb_rq; // Partner lines
  logic act, mon, flt, dec, r_to, r_s1, r_s2, os_act, os_flt; // Status
  logic [2:0] dem; // Demand code to the partner
  logic [3:0] par_index; // Parameter index
  logic [31:0] velocity, position, par_wdata, par_rdata; // Data
  int miscompares = 0, samples_checked = 0, n;
  int ref_par [0:15]; // Model of the settings
  logic [31:0] vals [10] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h6, 32'h7,
    32'h0000_ea60, 32'h0000_ea61, 32'h7fff_ffff, 32'h8000_0000};

  safe_io_model i_io (.demand_code(dem), .fb_on_cmd(fb_on),
    .fb_req_cmd(fb_req), .safe_input_one(s1), .safe_input_two(s2),
    .safe_input_three(s3), .safe_input_four(s4),
    .safety_fieldbus_on(fb_line), .stop_fieldbus_request(fb_rq));
  limited_speed_standstill_monitor #(.TICK_CYCLES(TCK)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .safe_input_one(s1),
    .safe_input_two(s2), .safe_input_three(s3), .safe_input_four(s4),
    .velocity(velocity), .position(position), .safe_encoder_present(enc),
    .safety_fieldbus_on(fb_line), .stop_input_request(stop_in),
    .stop_fieldbus_request(fb_rq), .par_wr_en(par_wr_en),
    .par_index(par_index), .par_wdata(par_wdata), .par_rdata(par_rdata),
    .par_refused(par_refused), .limited_speed_active(act),
    .limited_speed_monitoring(mon), .limited_speed_faulted(flt),
    .decel_monitor_active(dec), .torque_off_reaction(r_to),
    .controlled_stop_type_one(r_s1), .controlled_stop_type_two(r_s2),
    .operating_stop_active(os_act), .operating_stop_fault(os_flt));

  // Clock at 40 MHz
  initial begin
    clk_sys = 0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Verdict and end of run
  task automatic final_report;
    $display("Checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Single comparison point
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Wait cycles, landing just after the edge
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #2;
  endtask

  // Model acceptance of a write
  function automatic bit ok(input int i, input logic [31:0] v);
    case (i)
      0: ok = v <= 6;
      1, 2: ok = v >= 1 && v <= lss_pkg::MS_MAX;
      3: ok = v >= 2 && v <= lss_pkg::MS_MAX;
      4: ok = v >= 1 && v <= 32'h7fff_ffff;
      5: ok = v <= 1 && (v == 0 || fb_on);
      6: ok = v <= 1 && (v == 0 || enc);
      7: ok = v <= 1;
      8: ok = v >= 1 && v <= 3;
      9: ok = v <= 32'h7fff_ffff;
      default: ok = 0;
    endcase
  endfunction

  // Inputs a code selects or a demand pulls low
  function automatic logic [3:0] mask(input int c);
    case (c)
      1: mask = 4'h1;
      2: mask = 4'h2;
      3: mask = 4'h4;
      4: mask = 4'h8;
      5: mask = 4'h3;
      6: mask = 4'hc;
      default: mask = 4'h0;
    endcase
  endfunction

  // One write strobe, model updated when accepted
  task automatic wr(input int i, input logic [31:0] v);
    @(posedge clk_sys);
    #2 par_wr_en = 1;
    par_index = i[3:0];
    par_wdata = v;
    cyc(1);
    par_wr_en = 0;
    if (ok(i, v)) ref_par[i] = v;
  endtask

  // Read data shows the index one edge later
  task automatic rd(input int i);
    @(posedge clk_sys);
    #2 par_index = i[3:0];
    cyc(1);
  endtask

  // Status selector for bounded waits
  function automatic logic pick(input int w);
    case (w)
      0: pick = flt;
      1: pick = mon;
      default: pick = dec;
    endcase
  endfunction
  task automatic wait_sig(input int w, output int c);
    c = 0;
    while (pick(w) !== 1'b1 && c < 100) begin
      cyc(1);
      c++;
    end
  endtask

  // Watchdog on a hang
  initial begin
    #(25 * 30000);
    miscompares++;
    final_report;
  end

  // Main sequence
  initial begin
    {enc, stop_in, fb_on, fb_req, par_wr_en, dem, par_index} = '0;
    {velocity, position, par_wdata} = '0;
    reset = 1;
    n = $urandom(10);
    foreach (ref_par[i]) ref_par[i] = 0;
    ref_par[1] = 1;
    ref_par[2] = 1;
    ref_par[3] = 2;
    ref_par[4] = 1;
    ref_par[8] = 1;
    ref_par[9] = 1;
    cyc(20);
    check({act, flt, dec, os_act, par_refused}, 0);
    reset = 0;
    // Reset values of every setting
    for (int i = 0; i < 10; i++) begin
      rd(i);
      check(par_rdata, ref_par[i]);
    end
    // Range edges on indices 0 to 11, readback after each
    for (int i = 0; i < 12; i++) begin
      foreach (vals[j]) begin
        wr(i, vals[j]);
        check(par_refused, !ok(i, vals[j]));
        rd(i);
        if (i != 10) check(par_rdata, ref_par[i]);
      end
    end
    // Every trigger code against every demand pattern
    wr(4, 32'h0000_03e8);
    wr(7, 0);
    for (int c = 0; c < 7; c++) begin
      wr(0, c);
      for (int d = 1; d < 7; d++) begin
        dem = d[2:0];
        cyc(2);
        check(act, (mask(c) & mask(d)) != 0);
        dem = 0;
        cyc(2);
        check(act, 0);
      end
    end
    // Timeout with velocity at the limit, each reaction code
    wr(0, 1);
    wr(2, 3);
    wr(3, 5);
    wr(4, 100);
    for (int r = 1; r < 4; r++) begin
      wr(8, r);
      velocity = r[0] ? 32'h0000_0064 : 32'hffff_ff9c;
      dem = 1;
      wait_sig(0, n);
      check(n >= 16 && n <= 26, 1);
      check({r_to, r_s1, r_s2}, {r == 1, r == 2, r == 3});
      check(mon, 0);
      dem = 0;
      cyc(2);
      check(flt, 0);
    end
    // Settle in limit, then leave the limit
    wr(3, 2); // Timeout shorter than settle time
    velocity = $urandom_range(198) - 99;
    dem = 1;
    wait_sig(1, n);
    check(n >= 8 && n <= 18, 1);
    rd(10);
    check(par_rdata, 32'h0000_0003);
    check({flt, dec}, 0);
    velocity = 32'hffff_ff9c;
    cyc(3);
    check(flt, 1);
    dem = 0;
    // Deceleration checks after their delay
    wr(7, 1);
    wr(1, 4);
    velocity = 0;
    dem = 1;
    wait_sig(2, n);
    check(n >= 12 && n <= 22, 1);
    check(n > 0, 1);
    dem = 0;
    cyc(2);
    check(dec, 0);
    // Operating stop gating and position window
    wr(6, 1);
    check(par_refused, 1);
    enc = 1;
    wr(6, 1);
    check(par_refused, 0);
    wr(5, 1);
    check(par_refused, 1);
    fb_on = 1;
    wr(5, 1);
    check(par_refused, 0);
    wr(9, 10);
    position = $urandom;
    fb_req = 1;
    cyc(2);
    check(os_act, 1);
    position = position + 10;
    cyc(2);
    check(os_flt, 0);
    position = position + 1;
    cyc(2);
    check(os_flt, 1);
    fb_req = 0;
    cyc(2);
    check({os_act, os_flt}, 0);
    stop_in = 1;
    enc = 0;
    cyc(2);
    check(os_act, 0);
    enc = 1;
    cyc(2);
    check(os_act, 1);
    stop_in = 0;
    cyc(2);
    final_report;
  end
endmodule

// ---- hw/limited_speed_standstill_monitor.sv ----
// Purpose: Limited speed and operating stop supervision per instance
// Assumes: Safe inputs request the function when low
// Notes: Settings written over the parameter port, range checked
`timescale 1ns/1ps
module limited_speed_standstill_monitor #(
  parameter int TICK_CYCLES = lss_pkg::TICK_CYCLES // Cycles per ms
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Async reset, high
  input wire logic safe_input_one, // Safe input, low requests
  input wire logic safe_input_two, // Safe input, low requests
  input wire logic safe_input_three, // Safe input, low requests
  input wire logic safe_input_four, // Safe input, low requests
  input wire logic [31:0] velocity, // Signed encoder velocity
  input wire logic [31:0] position, // Encoder position
  input wire logic safe_encoder_present, // Safe encoder configured
  input wire logic safety_fieldbus_on, // Safety fieldbus activated
  input wire logic stop_input_request, // Operating stop input request
  input wire logic stop_fieldbus_request, // Operating stop over fieldbus
  input wire logic par_wr_en, // Parameter write strobe
  input wire logic [3:0] par_index, // Parameter index
  input wire logic [31:0] par_wdata, // Parameter write data
  output logic [31:0] par_rdata, // Parameter read data
  output logic par_refused, // Write refused pulse
  output logic limited_speed_active, // Function requested
  output logic limited_speed_monitoring, // Final monitoring state
  output logic limited_speed_faulted, // Faulted state
  output logic decel_monitor_active, // Deceleration checks running
  output logic torque_off_reaction, // Reaction torque off
  output logic controlled_stop_type_one, // Reaction stop type one
  output logic controlled_stop_type_two, // Reaction stop type two
  output logic operating_stop_active, // Operating stop monitoring
  output logic operating_stop_fault // Position left the window
);

  // Settings
  logic [2:0] trig_sel_ff; // Trigger selector
  logic [15:0] dec_delay_ff; // Decel monitor start delay
  logic [15:0] settle_ff; // In-limit settle time
  logic [15:0] timeout_ff; // Velocity reach timeout
  logic [31:0] limit_ff; // Speed limit value
  logic fb_en_ff; // Stop fieldbus enable
  logic act_ff; // Stop activation setting
  logic dec_en_ff; // Decel check enable
  logic [1:0] react_ff; // Fault reaction select
  logic [31:0] window_ff; // Standstill position window

  // Function state
  lss_pkg::ls_state_t st_ff; // Limited speed state
  logic [15:0] ms_cnt_ff; // ms since activation
  logic [15:0] settle_cnt_ff; // ms continuously in limit
  logic [31:0] cap_pos_ff; // Captured standstill position
  logic tick; // One ms enable
  logic req; // Selected trigger demands function
  logic accept; // Write within range
  logic in_limit; // Velocity below limit
  logic settle_done; // Settle time satisfied
  logic timeout_hit; // Timeout elapsed
  logic os_req; // Operating stop demanded
  logic [31:0] vel_mag; // Velocity magnitude
  logic [31:0] pos_diff; // Position minus captured
  logic [31:0] pos_mag; // Deviation magnitude

  ms_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk_sys(clk_sys),
    .reset(reset),
    .restart(st_ff == lss_pkg::LS_IDLE),
    .tick(tick)
  );

  // Trigger decode, dual pairs demand when either channel drops
  always_comb begin
    unique case (trig_sel_ff)
      lss_pkg::TRIG_IN1: req = !safe_input_one;
      lss_pkg::TRIG_IN2: req = !safe_input_two;
      lss_pkg::TRIG_IN3: req = !safe_input_three;
      lss_pkg::TRIG_IN4: req = !safe_input_four;
      lss_pkg::TRIG_DUAL12: req = !(safe_input_one && safe_input_two);
      lss_pkg::TRIG_DUAL34: req = !(safe_input_three && safe_input_four);
      default: req = 1'b0; // Code zero, nothing triggers
    endcase
  end

  // Range check of each write
  always_comb begin
    unique case (par_index)
      lss_pkg::IDX_TRIG_SEL: accept = par_wdata <= 32'(lss_pkg::TRIG_MAX);
      lss_pkg::IDX_DEC_DELAY, lss_pkg::IDX_SETTLE:
        accept = par_wdata >= 32'(lss_pkg::DELAY_MIN) &&
                 par_wdata <= 32'(lss_pkg::MS_MAX);
      lss_pkg::IDX_TIMEOUT:
        accept = par_wdata >= 32'(lss_pkg::TIMEOUT_MIN) &&
                 par_wdata <= 32'(lss_pkg::MS_MAX);
      lss_pkg::IDX_LIMIT:
        accept = par_wdata != 32'h0000_0000 &&
                 par_wdata <= lss_pkg::LIMIT_MAX;
      lss_pkg::IDX_FB_EN:
        accept = par_wdata == 32'h0000_0000 ||
                 (par_wdata == 32'h0000_0001 && safety_fieldbus_on);
      lss_pkg::IDX_ACT:
        accept = par_wdata == 32'h0000_0000 ||
                 (par_wdata == 32'h0000_0001 && safe_encoder_present);
      lss_pkg::IDX_DEC_EN: accept = par_wdata <= 32'h0000_0001;
      lss_pkg::IDX_REACT:
        accept = par_wdata >= 32'(lss_pkg::REACT_TORQUE_OFF) &&
                 par_wdata <= 32'(lss_pkg::REACT_STOP_TWO);
      lss_pkg::IDX_WINDOW: accept = par_wdata <= lss_pkg::LIMIT_MAX;
      default: accept = 1'b0; // Status and unmapped are read-only
    endcase
  end

  // Settings store, refused writes leave the value
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      trig_sel_ff <= lss_pkg::TRIG_RST;
      dec_delay_ff <= lss_pkg::DEC_DELAY_RST;
      settle_ff <= lss_pkg::SETTLE_RST;
      timeout_ff <= lss_pkg::TIMEOUT_RST;
      limit_ff <= lss_pkg::LIMIT_RST;
      fb_en_ff <= 1'b0;
      act_ff <= 1'b0;
      dec_en_ff <= 1'b0;
      react_ff <= lss_pkg::REACT_RST;
      window_ff <= lss_pkg::WINDOW_RST;
    end else if (par_wr_en && accept) begin
      unique case (par_index)
        lss_pkg::IDX_TRIG_SEL: trig_sel_ff <= par_wdata[2:0];
        lss_pkg::IDX_DEC_DELAY: dec_delay_ff <= par_wdata[15:0];
        lss_pkg::IDX_SETTLE: settle_ff <= par_wdata[15:0];
        lss_pkg::IDX_TIMEOUT: timeout_ff <= par_wdata[15:0];
        lss_pkg::IDX_LIMIT: limit_ff <= par_wdata;
        lss_pkg::IDX_FB_EN: fb_en_ff <= par_wdata[0];
        lss_pkg::IDX_ACT: act_ff <= par_wdata[0];
        lss_pkg::IDX_DEC_EN: dec_en_ff <= par_wdata[0];
        lss_pkg::IDX_REACT: react_ff <= par_wdata[1:0];
        lss_pkg::IDX_WINDOW: window_ff <= par_wdata;
        default: ;
      endcase
    end
  end

  // Refusal flag and registered read data
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      par_refused <= 1'b0;
      par_rdata <= 32'h0000_0000;
    end else begin
      par_refused <= par_wr_en && !accept;
      unique case (par_index)
        lss_pkg::IDX_TRIG_SEL: par_rdata <= 32'(trig_sel_ff);
        lss_pkg::IDX_DEC_DELAY: par_rdata <= 32'(dec_delay_ff);
        lss_pkg::IDX_SETTLE: par_rdata <= 32'(settle_ff);
        lss_pkg::IDX_TIMEOUT: par_rdata <= 32'(timeout_ff);
        lss_pkg::IDX_LIMIT: par_rdata <= limit_ff;
        lss_pkg::IDX_FB_EN: par_rdata <= 32'(fb_en_ff);
        lss_pkg::IDX_ACT: par_rdata <= 32'(act_ff);
        lss_pkg::IDX_DEC_EN: par_rdata <= 32'(dec_en_ff);
        lss_pkg::IDX_REACT: par_rdata <= 32'(react_ff);
        lss_pkg::IDX_WINDOW: par_rdata <= window_ff;
        lss_pkg::IDX_STATUS:
          par_rdata <= {26'h000_0000, operating_stop_fault,
                        operating_stop_active, decel_monitor_active,
                        limited_speed_faulted, limited_speed_monitoring,
                        limited_speed_active};
        default: par_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Velocity comparison against the limit
  assign vel_mag = velocity[31] ? (~velocity + 32'h0000_0001) : velocity;
  assign in_limit = vel_mag < limit_ff;
  assign settle_done = in_limit && settle_cnt_ff >= settle_ff;
  assign timeout_hit = !in_limit && ms_cnt_ff >= timeout_ff;

  // Millisecond counters, cleared while idle so each activation restarts
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ms_cnt_ff <= 16'h0000;
      settle_cnt_ff <= 16'h0000;
    end else if (st_ff == lss_pkg::LS_IDLE) begin
      ms_cnt_ff <= 16'h0000;
      settle_cnt_ff <= 16'h0000;
    end else begin
      if (tick && ms_cnt_ff != 16'hffff)
        ms_cnt_ff <= ms_cnt_ff + 16'h0001;
      if (!in_limit)
        settle_cnt_ff <= 16'h0000;
      else if (tick && settle_cnt_ff != 16'hffff)
        settle_cnt_ff <= settle_cnt_ff + 16'h0001;
    end
  end

  // Limited speed sequence; fault holds until the demand drops
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_ff <= lss_pkg::LS_IDLE;
    end else begin
      unique case (st_ff)
        lss_pkg::LS_IDLE:
          if (req) st_ff <= lss_pkg::LS_SETTLE;
        lss_pkg::LS_SETTLE:
          if (!req) st_ff <= lss_pkg::LS_IDLE;
          else if (settle_done) st_ff <= lss_pkg::LS_MONITOR;
          else if (timeout_hit) st_ff <= lss_pkg::LS_FAULT;
        lss_pkg::LS_MONITOR:
          if (!req) st_ff <= lss_pkg::LS_IDLE;
          else if (!in_limit) st_ff <= lss_pkg::LS_FAULT;
        lss_pkg::LS_FAULT:
          if (!req) st_ff <= lss_pkg::LS_IDLE;
      endcase
    end
  end

  // Status and reaction outputs
  assign limited_speed_active = st_ff != lss_pkg::LS_IDLE;
  assign limited_speed_monitoring = st_ff == lss_pkg::LS_MONITOR;
  assign limited_speed_faulted = st_ff == lss_pkg::LS_FAULT;
  assign decel_monitor_active = dec_en_ff && limited_speed_active &&
                                ms_cnt_ff >= dec_delay_ff;
  assign torque_off_reaction = limited_speed_faulted &&
    react_ff == lss_pkg::REACT_TORQUE_OFF;
  assign controlled_stop_type_one = limited_speed_faulted &&
    react_ff == lss_pkg::REACT_STOP_ONE;
  assign controlled_stop_type_two = limited_speed_faulted &&
    react_ff == lss_pkg::REACT_STOP_TWO;

  // Operating stop demand, gated by activation and encoder
  assign os_req = act_ff && safe_encoder_present &&
                  (stop_input_request || (fb_en_ff && stop_fieldbus_request));
  assign pos_diff = position - cap_pos_ff;
  assign pos_mag = pos_diff[31] ? (~pos_diff + 32'h0000_0001) : pos_diff;

  // Capture position on entry, flag departures beyond the window
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      operating_stop_active <= 1'b0;
      operating_stop_fault <= 1'b0;
      cap_pos_ff <= 32'h0000_0000;
    end else if (!os_req) begin
      operating_stop_active <= 1'b0;
      operating_stop_fault <= 1'b0;
    end else if (!operating_stop_active) begin
      operating_stop_active <= 1'b1;
      cap_pos_ff <= position;
    end else if (pos_mag > window_ff) begin
      operating_stop_fault <= 1'b1;
    end
  end

  // Checks
  a_trig_code: assert property (@(posedge clk_sys) disable iff (reset)
    trig_sel_ff <= lss_pkg::TRIG_MAX)
    else $error("trigger selector out of range");
  a_decel_after_delay: assert property (@(posedge clk_sys)
    disable iff (reset) $rose(decel_monitor_active) |->
    ms_cnt_ff >= dec_delay_ff && dec_delay_ff >= lss_pkg::DELAY_MIN)
    else $error("decel monitoring began before its delay");
  a_decel_gated: assert property (@(posedge clk_sys) disable iff (reset)
    !dec_en_ff |-> !decel_monitor_active)
    else $error("decel monitoring while disabled");
  a_settle_first: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(limited_speed_monitoring) |-> $past(settle_done) &&
    $past(in_limit))
    else $error("monitoring entered without settle time");
  a_timeout_fault: assert property (@(posedge clk_sys) disable iff (reset)
    (st_ff == lss_pkg::LS_SETTLE && req && timeout_hit && !settle_done)
    |=> limited_speed_faulted)
    else $error("timeout did not fault");
  a_limit_range: assert property (@(posedge clk_sys) disable iff (reset)
    limit_ff != 32'h0000_0000 && !limit_ff[31])
    else $error("speed limit out of range");
  a_fb_gate: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(fb_en_ff) |-> $past(safety_fieldbus_on))
    else $error("fieldbus enable set without fieldbus");
  a_stop_encoder: assert property (@(posedge clk_sys) disable iff (reset)
    operating_stop_active |-> $past(act_ff) &&
    $past(safe_encoder_present))
    else $error("operating stop without encoder");
  a_reaction_map: assert property (@(posedge clk_sys) disable iff (reset)
    limited_speed_faulted |-> (react_ff == lss_pkg::REACT_STOP_ONE) ==
    controlled_stop_type_one && (react_ff == lss_pkg::REACT_TORQUE_OFF) ==
    torque_off_reaction)
    else $error("reaction output mismatch");
  a_window_fault: assert property (@(posedge clk_sys) disable iff (reset)
    (operating_stop_active && os_req && pos_mag > window_ff) |=>
    operating_stop_fault)
    else $error("window departure not flagged");
  a_tick_count: assert property (@(posedge clk_sys) disable iff (reset)
    (limited_speed_active && !tick && $past(limited_speed_active))
    |=> $stable(ms_cnt_ff) || !limited_speed_active)
    else $error("timer moved without a tick");
endmodule

// ---- hw/lss_pkg.sv ----
// Purpose: Shared constants and types for the limited speed monitor
// Assumes: 40 MHz system clock, millisecond time base
// Notes: Parameter indices select settings on the parameter port
package lss_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS = 25; // System clock period
  localparam int MS_PERIOD_NS = 1000000; // One millisecond
  localparam int TICK_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS; // 40000

  // Parameter indices on the parameter port
  localparam logic [3:0] IDX_TRIG_SEL = 4'h0; // Trigger selector
  localparam logic [3:0] IDX_DEC_DELAY = 4'h1; // Decel monitor start delay
  localparam logic [3:0] IDX_SETTLE = 4'h2; // In-limit settle time
  localparam logic [3:0] IDX_TIMEOUT = 4'h3; // Velocity reach timeout
  localparam logic [3:0] IDX_LIMIT = 4'h4; // Speed limit value
  localparam logic [3:0] IDX_FB_EN = 4'h5; // Stop fieldbus enable
  localparam logic [3:0] IDX_ACT = 4'h6; // Stop activation setting
  localparam logic [3:0] IDX_DEC_EN = 4'h7; // Decel check enable
  localparam logic [3:0] IDX_REACT = 4'h8; // Fault reaction select
  localparam logic [3:0] IDX_WINDOW = 4'h9; // Standstill position window
  localparam logic [3:0] IDX_STATUS = 4'ha; // Read-only status

  // Reset values
  localparam logic [2:0] TRIG_RST = 3'h0; // No input
  localparam logic [15:0] DEC_DELAY_RST = 16'h0001; // 1 ms
  localparam logic [15:0] SETTLE_RST = 16'h0001; // 1 ms
  localparam logic [15:0] TIMEOUT_RST = 16'h0002; // 2 ms
  localparam logic [31:0] LIMIT_RST = 32'h0000_0001; // One user unit
  localparam logic [1:0] REACT_RST = 2'h1; // Torque off
  localparam logic [31:0] WINDOW_RST = 32'h0000_0001; // One user unit

  // Ranges
  localparam logic [2:0] TRIG_MAX = 3'h6; // Highest selector code
  localparam logic [15:0] MS_MAX = 16'hea60; // 60000 ms
  localparam logic [15:0] DELAY_MIN = 16'h0001; // Delay and settle floor
  localparam logic [15:0] TIMEOUT_MIN = 16'h0002; // Timeout floor
  localparam logic [31:0] LIMIT_MAX = 32'h7fff_ffff; // 2^31-1

  // Trigger selector codes
  localparam logic [2:0] TRIG_NONE = 3'h0; // Not used
  localparam logic [2:0] TRIG_IN1 = 3'h1; // Safe input one
  localparam logic [2:0] TRIG_IN2 = 3'h2; // Safe input two
  localparam logic [2:0] TRIG_IN3 = 3'h3; // Safe input three
  localparam logic [2:0] TRIG_IN4 = 3'h4; // Safe input four
  localparam logic [2:0] TRIG_DUAL12 = 3'h5; // Pair one/two
  localparam logic [2:0] TRIG_DUAL34 = 3'h6; // Pair three/four

  // Fault reaction codes
  localparam logic [1:0] REACT_TORQUE_OFF = 2'h1; // Torque off
  localparam logic [1:0] REACT_STOP_ONE = 2'h2; // Controlled stop type one
  localparam logic [1:0] REACT_STOP_TWO = 2'h3; // Controlled stop type two

  // Limited speed function states
  typedef enum logic [2:0] {
    LS_IDLE,
    LS_SETTLE,
    LS_MONITOR,
    LS_FAULT
  } ls_state_t;

endpackage

// ---- hw/ms_tick.sv ----
// Purpose: Millisecond enable pulse from the system clock
// Assumes: Divider held at zero by restart, one-cycle pulse
// Notes: Period set by the cycles parameter
`timescale 1ns/1ps
module ms_tick #(
  parameter int TICK_CYCLES = lss_pkg::TICK_CYCLES // Cycles per tick
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Async reset, high
  input wire logic restart, // Hold divider at zero
  output logic tick // One-cycle pulse each ms
);

  logic [31:0] cnt_ff; // Divider count

  // Divider wraps after the period and fires the tick
  // Restart keeps the first period whole, so no delay is cut short
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_ff <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (restart) begin
      cnt_ff <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (cnt_ff >= 32'(TICK_CYCLES - 1)) begin
      cnt_ff <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

endmodule
